// ===== rtl/apc_pkg.sv
`default_nettype none
package apc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register addresses on the special-function-register bus.
  localparam logic [7:0] ADDR_IRQ_EN_SECOND  = 8'h9a;
  localparam logic [7:0] ADDR_AMP_CTRL       = 8'h9b;
  localparam logic [7:0] ADDR_IRQ_EN_FIRST   = 8'ha8;
  localparam logic [7:0] ADDR_IRQ_REQ_SECOND = 8'hbf;
  localparam logic [7:0] ADDR_P1_ANALOG_CFG  = 8'hd6;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'he0;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'he1;

  // Field positions.
  localparam int unsigned BIT_GLOBAL_IRQ_EN = 7;
  localparam int unsigned BIT_CMP_IRQ_EN    = 2;
  localparam int unsigned BIT_CMP_IRQ_FLAG  = 1;
  localparam int unsigned BIT_AMP_EN        = 0;
  localparam int unsigned P1CFG_LO          = 3;
  localparam int unsigned P1CFG_HI          = 5;
  localparam int unsigned P1CFG_W           = P1CFG_HI - P1CFG_LO + 1;

  // Shared port 1 pin indices for the amplifier.
  localparam int unsigned PIN_AMP_OUT = 3;
  localparam int unsigned PIN_AMP_POS = 4;
  localparam int unsigned PIN_AMP_NEG = 5;

  // ADC channel code that selects the amplifier output.
  localparam logic [3:0] ADC_CHANNEL_ELEVEN = 4'hb;

  // Event status bits for the status and mask registers.
  localparam int unsigned EVT_CMP_EDGE = 0;
  localparam int unsigned EVT_W        = 1;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Pin-sharing outputs that travel together.
  typedef struct packed {
    logic [P1CFG_W-1:0] gpio_cut;
    logic               amp_enable;
    logic               adc_amp_selected;
  } apc_pinmux_s;

  typedef struct packed {
    logic               global_irq_enable;
    logic               comparator_irq_enable;
    logic               comparator_irq_flag;
    logic               amp_enable;
    logic [P1CFG_W-1:0] port1_analog_config;
    logic [EVT_W-1:0]   evt_status;
    logic [EVT_W-1:0]   evt_mask;
    logic [7:0]         rd_data;
    logic               cmp_irq_req;
    logic               irq;
    apc_pinmux_s        pinmux;
  } apc_state_s;

endpackage
`default_nettype wire

// ===== rtl/apc_regs.sv
// Operation
// RQ1 - Global interrupt enable, bit 7 at 0xA8
// RQ2 - Comparator interrupt enable, bit 2 at 0x9A
// RQ3 - Comparator request flag, bit 1 at 0xBF
// RQ4 - Request only when flag and both enables
// RQ5 - Hardware sets flag on edge; software clears
// RQ6 - Amplifier enable bit 0 at 0x9B
// RQ7 - Enabled amplifier cuts GPIO paths of pins
// RQ8 - Output P1.3, positive P1.4, negative P1.5
// RQ9 - Amplifier output routed to ADC channel eleven
// RQ10 - Port 1 pure-analog bits 5..3 at 0xD6
// RQ11 - Other amplifier control bits read zero
// RQ12 - Software clears flag by read-modify-write
//
// Strobed register access was left to the implementer.
`default_nettype none
module apc_regs (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  // Register port
  input  wire logic [apc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [apc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [apc_pkg::DATA_W-1:0]    reg_rdata,
  // Comparator event and ADC selection
  input  wire logic                          cmp_edge,
  input  wire logic [3:0]                    adc_channel_select,
  // Pin sharing and requests
  output apc_pkg::apc_pinmux_s               pinmux,
  output logic                               cmp_irq_req,
  output logic                               irq
);

  apc_pkg::apc_state_s st;
  apc_pkg::apc_state_s next_st;

  logic wr_en2, wr_amp, wr_en0, wr_req2, wr_p1, wr_mask;
  logic rd_req2, rd_status;

  always_comb begin
    wr_en2    = reg_wr && (reg_addr == apc_pkg::ADDR_IRQ_EN_SECOND);
    wr_amp    = reg_wr && (reg_addr == apc_pkg::ADDR_AMP_CTRL);
    wr_en0    = reg_wr && (reg_addr == apc_pkg::ADDR_IRQ_EN_FIRST);
    wr_req2   = reg_wr && (reg_addr == apc_pkg::ADDR_IRQ_REQ_SECOND);
    wr_p1     = reg_wr && (reg_addr == apc_pkg::ADDR_P1_ANALOG_CFG);
    wr_mask   = reg_wr && (reg_addr == apc_pkg::ADDR_IRQ_MASK);
    rd_req2   = reg_rd && (reg_addr == apc_pkg::ADDR_IRQ_REQ_SECOND);
    rd_status = reg_rd && (reg_addr == apc_pkg::ADDR_IRQ_STATUS);
  end

  always_comb begin
    next_st = st;
    if (wr_en0) begin
      next_st.global_irq_enable = reg_wdata[apc_pkg::BIT_GLOBAL_IRQ_EN]; // RQ1
    end
    if (wr_en2) begin
      next_st.comparator_irq_enable = reg_wdata[apc_pkg::BIT_CMP_IRQ_EN]; // RQ2
    end
    if (wr_amp) begin
      next_st.amp_enable = reg_wdata[apc_pkg::BIT_AMP_EN]; // RQ6
    end
    if (wr_p1) begin
      next_st.port1_analog_config = reg_wdata[apc_pkg::P1CFG_HI:apc_pkg::P1CFG_LO]; // RQ10
    end
    if (wr_mask) begin
      next_st.evt_mask = reg_wdata[apc_pkg::EVT_W-1:0];
    end
    // Software may only clear the flag; a same-cycle edge wins over the clear.
    if (wr_req2) begin
      next_st.comparator_irq_flag = st.comparator_irq_flag
                                    & reg_wdata[apc_pkg::BIT_CMP_IRQ_FLAG]; // RQ5
    end
    if (cmp_edge) begin
      next_st.comparator_irq_flag = 1'b1; // RQ5
    end
    // Status is read-to-clear, but a new event in the read cycle survives.
    if (rd_status) begin
      next_st.evt_status = '0;
    end
    if (cmp_edge) begin
      next_st.evt_status[apc_pkg::EVT_CMP_EDGE] = 1'b1;
    end

    next_st.rd_data = apc_pkg::RESET_BYTE;
    if (reg_rd) begin
      if (reg_addr == apc_pkg::ADDR_IRQ_EN_FIRST) begin
        next_st.rd_data[apc_pkg::BIT_GLOBAL_IRQ_EN] = st.global_irq_enable; // RQ1
      end else if (reg_addr == apc_pkg::ADDR_IRQ_EN_SECOND) begin
        next_st.rd_data[apc_pkg::BIT_CMP_IRQ_EN] = st.comparator_irq_enable; // RQ2
      end else if (rd_req2) begin
        next_st.rd_data[apc_pkg::BIT_CMP_IRQ_FLAG] = st.comparator_irq_flag; // RQ3
      end else if (reg_addr == apc_pkg::ADDR_AMP_CTRL) begin
        next_st.rd_data[apc_pkg::BIT_AMP_EN] = st.amp_enable; // RQ11
      end else if (reg_addr == apc_pkg::ADDR_P1_ANALOG_CFG) begin
        next_st.rd_data[apc_pkg::P1CFG_HI:apc_pkg::P1CFG_LO] = st.port1_analog_config; // RQ10
      end else if (rd_status) begin
        next_st.rd_data[apc_pkg::EVT_W-1:0] = st.evt_status;
      end else if (reg_addr == apc_pkg::ADDR_IRQ_MASK) begin
        next_st.rd_data[apc_pkg::EVT_W-1:0] = st.evt_mask;
      end
    end

    // Taken from the current registers, so the request lags a change by one cycle.
    next_st.cmp_irq_req = st.comparator_irq_flag && st.comparator_irq_enable
                          && st.global_irq_enable; // RQ4
    next_st.irq = |(next_st.evt_status & next_st.evt_mask);

    // The gpio cut covers P1.3..P1.5: amplifier use or pure-analog config.
    next_st.pinmux.amp_enable = next_st.amp_enable; // RQ7 RQ8
    next_st.pinmux.gpio_cut = next_st.port1_analog_config
                              | {apc_pkg::P1CFG_W{next_st.amp_enable}}; // RQ7 RQ10
    next_st.pinmux.adc_amp_selected = next_st.amp_enable
                              && (adc_channel_select == apc_pkg::ADC_CHANNEL_ELEVEN); // RQ9
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata   = st.rd_data;
  assign pinmux      = st.pinmux;
  assign cmp_irq_req = st.cmp_irq_req;
  assign irq         = st.irq;

endmodule
`default_nettype wire

// ===== verif/apc_regs_chk.sv
`default_nettype none
module apc_regs_chk (
  input wire logic                 sys_clk, rst_n, clk_en, reg_wr, reg_rd, cmp_edge,
  input wire logic                 cmp_irq_req, irq,
  input wire logic [7:0]           reg_addr, reg_wdata, reg_rdata,
  input wire logic [3:0]           adc_channel_select,
  input wire apc_pkg::apc_pinmux_s pinmux
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rsv; reg_rd && clk_en && reg_addr == 8'h9b |=> reg_rdata[7:1] == 7'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_gie; reg_wr && clk_en && reg_addr == 8'ha8 && !reg_wdata[7] ##1 clk_en
    |=> !cmp_irq_req; endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_cie; reg_wr && clk_en && reg_addr == 8'h9a && !reg_wdata[2] ##1 clk_en
    |=> !cmp_irq_req; endproperty
  a_cie: assert property (p_cie) else $error("request without comparator enable");
  property p_set; cmp_edge && clk_en ##1 !reg_wr ##1 reg_rd && clk_en && reg_addr == 8'hbf
    |=> reg_rdata[1]; endproperty
  a_set: assert property (p_set) else $error("flag not set by edge");
  property p_cut; pinmux.amp_enable |-> pinmux.gpio_cut == 3'h7; endproperty
  a_cut: assert property (p_cut) else $error("gpio path not cut");
  property p_adc; pinmux.adc_amp_selected && $past(clk_en)
    |-> $past(adc_channel_select) == 4'hb; endproperty
  a_adc: assert property (p_adc) else $error("adc selection wrong");
  property p_unm; reg_rd && clk_en && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_idle; !reg_rd && clk_en |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
endmodule
bind apc_regs apc_regs_chk u_chk (.*);
`default_nettype wire

// ===== verif/test_apc_regs.sv
`default_nettype none
module test_apc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk, rst_n, clk_en, reg_wr, reg_rd, cmp_edge, cmp_irq_req, irq;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata;
  logic [3:0]           adc_channel_select;
  apc_pkg::apc_pinmux_s pinmux;
  int                   n_fail = 0;
  int                   num_checks = 0;
  logic [7:0]           ra [5] = '{8'h9a, 8'h9b, 8'ha8, 8'hbf, 8'hd6};
  apc_regs u_dut (.*);
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic pulse;
    @(posedge sys_clk);
    cmp_edge <= 1'b1;
    @(posedge sys_clk);
    cmp_edge <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Clock enable drops once near the end to show that a write is frozen out.
  initial begin
    {rst_n, reg_wr, reg_rd, cmp_edge, reg_addr, reg_wdata, adc_channel_select} = '0;
    clk_en = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'hff);
    adc_channel_select <= 4'hb;
    wr(8'h9b, 8'hff);
    rd(8'h9b, 8'h01);
    chk("pinmux", 8'h1f, {3'h0, pinmux});
    wr(8'h9b, 8'h00);
    wr(8'hd6, 8'hff);
    rd(8'hd6, 8'h38);
    chk("pinmux", 8'h1c, {3'h0, pinmux});
    wr(8'hd6, 8'h00);
    wr(8'ha8, 8'h80);
    wr(8'h9a, 8'h04);
    rd(8'ha8, 8'h80);
    rd(8'h9a, 8'h04);
    pulse;
    #1 chk("irq", 8'h00, {7'h0, irq});
    rd(8'hbf, 8'h02);
    chk("req", 8'h01, {7'h0, cmp_irq_req});
    wr(8'he1, 8'h01);
    @(posedge sys_clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    rd(8'he0, 8'h01);
    @(posedge sys_clk);
    #1 chk("irq", 8'h00, {7'h0, irq});
    wr(8'hbf, 8'hfd);
    rd(8'hbf, 8'h00);
    chk("req", 8'h00, {7'h0, cmp_irq_req});
    pulse;
    wr(8'ha8, 8'h00);
    @(posedge sys_clk);
    #1 chk("req", 8'h00, {7'h0, cmp_irq_req});
    rd(8'hbf, 8'h02);
    wr(8'h9a, 8'h00);
    clk_en <= 1'b0;
    wr(8'h9b, 8'h01);
    clk_en <= 1'b1;
    rd(8'h9b, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
